// ===== inc/nv_access_pkg.sv
// Purpose: shared constants for the lock and fuse access block
// Assumes: 32-bit AXI4-Lite register bus, RC oscillator tick as timing base
// Notes:   all offsets are byte addresses of aligned words
package nv_access_pkg;

	// register bus shape
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_POINTER = 8'h04;
	localparam logic [7:0] OFS_SOURCE  = 8'h08;
	localparam logic [7:0] OFS_INSTR   = 8'h0c;
	localparam logic [7:0] OFS_RESULT  = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h14;

	// store_program_control fields
	localparam int CTL_SPM_EN     = 0;
	localparam int CTL_PAGE_ERASE = 1;
	localparam int CTL_PAGE_WRITE = 2;
	localparam int CTL_LOCK_SEL   = 3;
	localparam int CTL_RWW_REEN   = 4;
	localparam int CTL_CMD_W      = 5;
	localparam int CTL_RWW_BUSY   = 6;

	// instruction strobe, result and status fields
	localparam int INSTR_STORE = 0;
	localparam int INSTR_LOAD  = 1;
	localparam int RES_VALID   = 8;
	localparam int RES_REFUSED = 9;
	localparam int ST_EE_BUSY  = 0;
	localparam int ST_WR_BUSY  = 1;
	localparam int ST_WINDOW   = 2;
	localparam int ST_ST_REFUSED = 3;

	// pointer values selecting the nonvolatile bytes
	localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
	localparam logic [15:0] PTR_LOCK      = 16'h0001;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

	// lock byte layout and erased value
	localparam logic [7:0] LOCK_ERASED   = 8'hff;
	localparam logic [7:0] UNMAPPED_BYTE = 8'hff;
	localparam int LOCK_BOOT_LSB = 2;
	localparam int LOCK_BOOT_MSB = 5;

	// arming windows in cpu cycles
	localparam logic [2:0] LOAD_WINDOW  = 3'h3;
	localparam logic [2:0] STORE_WINDOW = 3'h4;

	// flash write timing from the rc oscillator
	localparam int PROG_MIN_TIME_US = 3700;
	localparam int PROG_MAX_TIME_US = 4500;
	localparam int RC_FREQ_KHZ      = 1000;
	localparam int PROG_MIN_TICKS   = (PROG_MIN_TIME_US * RC_FREQ_KHZ + 999) / 1000;
	localparam int PROG_MAX_TICKS   = (PROG_MAX_TIME_US * RC_FREQ_KHZ) / 1000;
	localparam int PROG_TICKS_DEF   = (PROG_MIN_TICKS + PROG_MAX_TICKS) / 2;
	localparam int TICK_W           = 13;

	typedef enum logic {NV_IDLE, NV_WRITE} nv_state_t;

endpackage : nv_access_pkg

// ===== inc/nv_prog_if.sv
// Purpose: carrier between the access logic and the flash write timer
// Assumes: both ends on aclk
// Notes:   start is a one-cycle pulse, busy a level
`timescale 1ns/100ps
`default_nettype none
interface nv_prog_if;
	logic       start;      // begin a timed flash write
	logic       start_lock; // write targets the lock byte
	logic [7:0] lock_src;   // source byte for lock programming
	logic       busy;       // timed write under way
	logic [7:0] lock_byte;  // current lock byte
	modport ctl   (output start, output start_lock, output lock_src,
	               input busy, input lock_byte);
	modport store (input start, input start_lock, input lock_src,
	               output busy, output lock_byte);
endinterface : nv_prog_if
`default_nettype wire

// ===== rtl/nv_write_timer.sv
// Purpose: times flash and lock writes and holds the lock byte
// Assumes: rc_tick is a one-cycle pulse per rc oscillator period
// Notes:   system reset is not wired here so a write in flight completes
`timescale 1ns/100ps
`default_nettype none
module nv_write_timer
	import nv_access_pkg::*;
#(
	parameter int PROG_TICKS = nv_access_pkg::PROG_TICKS_DEF
) (
	input  wire logic aclk,    // cpu clock
	input  wire logic por_n,   // power-on reset, synchronous, active low
	input  wire logic rc_tick, // rc oscillator period pulse
	nv_prog_if.store  nv       // start and status
);
	nv_state_t         state;
	logic [TICK_W-1:0] cnt;
	logic              kind_lock;
	logic [7:0]        src;
	logic [7:0]        lock_byte;
	wire               last_tick = rc_tick && (cnt == TICK_W'(PROG_TICKS - 1));

	assign nv.busy      = (state == NV_WRITE);
	assign nv.lock_byte = lock_byte;

	// write sequencer; only power-on reset stops it, never the cpu reset
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			state     <= NV_IDLE;
			cnt       <= '0;
			kind_lock <= 1'b0;
			src       <= LOCK_ERASED;
		end else begin
			case (state)
				NV_IDLE: begin
					cnt <= '0;
					if (nv.start) begin
						state     <= NV_WRITE;
						kind_lock <= nv.start_lock;
						src       <= nv.lock_src;
					end
				end
				NV_WRITE: begin
					if (last_tick) begin
						state <= NV_IDLE;
					end else if (rc_tick) begin
						cnt <= cnt + 1'b1;
					end
				end
				default: state <= NV_IDLE;
			endcase
		end
	end

	// boot lock bits only ever go to programmed where the source bit is zero
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			lock_byte <= LOCK_ERASED;
		end else if (state == NV_WRITE && last_tick && kind_lock) begin
			lock_byte[LOCK_BOOT_MSB:LOCK_BOOT_LSB] <=
				lock_byte[LOCK_BOOT_MSB:LOCK_BOOT_LSB] & src[LOCK_BOOT_MSB:LOCK_BOOT_LSB];
		end
	end

	AST_PROG_TIME: assert property (@(posedge aclk) disable iff (!por_n)
		state == NV_WRITE && rc_tick && cnt != TICK_W'(PROG_TICKS - 1) |=> state == NV_WRITE)
		else $error("flash write ended before its programming time");

	AST_LOCK_PROG: assert property (@(posedge aclk) disable iff (!por_n)
		state == NV_WRITE && last_tick && kind_lock
		|=> lock_byte[5:2] == ($past(lock_byte[5:2]) & $past(src[5:2])))
		else $error("boot lock bits not programmed from source byte");

endmodule : nv_write_timer
`default_nettype wire

// ===== rtl/self_program_lock_fuse_access.sv
// Purpose: software access to boot lock programming and fuse/lock reads
// Assumes: store and load program instructions arrive as register strobes
// Notes:   eeprom busy, rc clock and fuse bytes are pins and are synchronised
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - armed store within four cycles programs boot lock bits whose source bit is zero
// - whole program memory stays readable while lock bits are programmed
// - an eeprom write in progress blocks every flash programming store
// - an eeprom write in progress refuses fuse and lock reads
// - armed load within three cycles at lock address returns the lock byte
// - arming bits clear after an armed lock or fuse read, after a store, or when the store window runs out
// - with arming clear, loads are ordinary program memory reads
// - armed load at address zero returns the fuse low byte unchanged
// - armed load at address three returns the fuse high byte unchanged
// - programmed bits read zero, unprogrammed bits read one
// - a flash write under way finishes even when system reset arrives
// - flash write timing comes from the rc oscillator, not the cpu clock
// - each timed write lasts between the minimum and maximum programming time
// - program-enable reads set until the previous store operation finishes
// - section busy flag stays set until a re-enable store or system reset clears it
module self_program_lock_fuse_access
	import nv_access_pkg::*;
#(
	parameter int PROG_TICKS = nv_access_pkg::PROG_TICKS_DEF
) (
	input  wire logic                              aclk,              // cpu clock
	input  wire logic                              aresetn,           // system reset
	input  wire logic                              por_n,             // power-on reset
	input  wire logic [nv_access_pkg::AXI_AW-1:0]  s_axi_awaddr,      // write address
	input  wire logic                              s_axi_awvalid,     // write address valid
	output var  logic                              s_axi_awready,     // write address ready
	input  wire logic [nv_access_pkg::AXI_DW-1:0]  s_axi_wdata,       // write data
	input  wire logic [3:0]                        s_axi_wstrb,       // byte strobes
	input  wire logic                              s_axi_wvalid,      // write data valid
	output var  logic                              s_axi_wready,      // write data ready
	output var  logic [1:0]                        s_axi_bresp,       // write response
	output var  logic                              s_axi_bvalid,      // write response valid
	input  wire logic                              s_axi_bready,      // write response ready
	input  wire logic [nv_access_pkg::AXI_AW-1:0]  s_axi_araddr,      // read address
	input  wire logic                              s_axi_arvalid,     // read address valid
	output var  logic                              s_axi_arready,     // read address ready
	output var  logic [nv_access_pkg::AXI_DW-1:0]  s_axi_rdata,       // read data
	output var  logic [1:0]                        s_axi_rresp,       // read response
	output var  logic                              s_axi_rvalid,      // read data valid
	input  wire logic                              s_axi_rready,      // read data ready
	input  wire logic                              eeprom_write_busy, // eeprom write running
	input  wire logic                              rc_osc,            // rc oscillator
	input  wire logic [7:0]                        fuse_low_byte,     // fuse low bits
	input  wire logic [7:0]                        fuse_high_byte,    // fuse high bits
	output var  logic [15:0]                       pmem_addr,         // program memory byte address
	output var  logic                              pmem_rd,           // program memory read pulse
	input  wire logic [7:0]                        pmem_rdata,        // program memory data
	output var  logic                              flash_busy         // timed write under way
);
	nv_prog_if nv ();

	// pin synchronisers; first stages feed only second stages
	logic       ee_meta, ee_busy, rc_meta, rc_sync, rc_prev;
	logic [7:0] flo_meta, fuse_lo, fhi_meta, fuse_hi;
	always_ff @(posedge aclk) begin
		ee_meta  <= eeprom_write_busy;
		ee_busy  <= ee_meta;
		rc_meta  <= rc_osc;
		rc_sync  <= rc_meta;
		rc_prev  <= rc_sync;
		flo_meta <= fuse_low_byte;
		fuse_lo  <= flo_meta;
		fhi_meta <= fuse_high_byte;
		fuse_hi  <= fhi_meta;
	end

	wire rc_tick = rc_sync & ~rc_prev; // one pulse per rc period

	nv_write_timer #(
		.PROG_TICKS (PROG_TICKS)
	) u_timer (
		.aclk    (aclk),
		.por_n   (por_n),
		.rc_tick (rc_tick),
		.nv      (nv.store)
	);

	// write channel: address and data taken in either order
	logic        aw_held, w_held;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic [3:0]  strb_q;
	wire         aw_ok   = s_axi_awvalid & s_axi_awready;
	wire         w_ok    = s_axi_wvalid & s_axi_wready;
	wire         wr_fire = (aw_held | aw_ok) & (w_held | w_ok) & ~s_axi_bvalid;
	wire [7:0]   wr_addr = aw_ok ? s_axi_awaddr : aw_q;
	wire [31:0]  wr_data = w_ok ? s_axi_wdata : w_q;
	wire [3:0]   wr_strb = w_ok ? s_axi_wstrb : strb_q;

	// write decode
	wire sel_ctrl   = wr_addr[7:2] == OFS_CTRL[7:2];
	wire sel_ptr    = wr_addr[7:2] == OFS_POINTER[7:2];
	wire sel_src    = wr_addr[7:2] == OFS_SOURCE[7:2];
	wire sel_instr  = wr_addr[7:2] == OFS_INSTR[7:2];
	wire wr_mapped  = sel_ctrl | sel_ptr | sel_src | sel_instr |
	                  wr_addr[7:2] == OFS_RESULT[7:2] | wr_addr[7:2] == OFS_STATUS[7:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (aw_ok)
				s_axi_awready <= 1'b0;
			if (w_ok)
				s_axi_wready <= 1'b0;
			aw_held <= ~wr_fire & (aw_held | aw_ok);
			w_held  <= ~wr_fire & (w_held | w_ok);
		end
	end

	// hold whichever half arrived first
	always_ff @(posedge aclk) begin
		if (aw_ok)
			aw_q <= s_axi_awaddr;
		if (w_ok) begin
			w_q    <= s_axi_wdata;
			strb_q <= s_axi_wstrb;
		end
	end

	// write response; unmapped addresses answer slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// software registers
	logic [15:0]          pointer;
	logic [7:0]           source;
	logic [CTL_CMD_W-1:0] cmd;
	logic                 win_open;
	logic [2:0]           win_cnt;
	logic                 rww_busy;
	logic                 store_refused;

	// pointer is kept for loads; lock writing never looks at it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pointer <= PTR_FUSE_LOW;
			source  <= LOCK_ERASED;
		end else if (wr_fire) begin
			if (sel_ptr && wr_strb[0])
				pointer[7:0] <= wr_data[7:0];
			if (sel_ptr && wr_strb[1])
				pointer[15:8] <= wr_data[15:8];
			if (sel_src && wr_strb[0])
				source <= wr_data[7:0];
		end
	end

	// instruction strobes and arming decode
	wire store_req  = wr_fire & sel_instr & wr_strb[0] & wr_data[INSTR_STORE];
	wire load_req   = wr_fire & sel_instr & wr_strb[0] & wr_data[INSTR_LOAD];
	// control writes are refused while a write is timed, so the command holds
	wire ctrl_wr    = wr_fire & sel_ctrl & wr_strb[0] & ~nv.busy & ~nv.start;
	wire load_armed = win_open & cmd[CTL_LOCK_SEL] & cmd[CTL_SPM_EN] &
	                  (win_cnt < LOAD_WINDOW);
	wire lock_load  = load_req & load_armed;
	wire plain_load = load_req & ~load_armed;
	wire store_hit  = store_req & win_open & (win_cnt < STORE_WINDOW);
	wire store_ok   = store_hit & ~ee_busy & ~nv.busy;
	wire page_cmd   = cmd[CTL_PAGE_ERASE] | cmd[CTL_PAGE_WRITE];
	wire start_lock = store_ok & cmd[CTL_LOCK_SEL];
	wire start_page = store_ok & ~cmd[CTL_LOCK_SEL] & page_cmd;
	wire reenable   = store_ok & ~cmd[CTL_LOCK_SEL] & ~page_cmd & cmd[CTL_RWW_REEN];
	wire win_end    = win_open & (win_cnt == STORE_WINDOW - 3'h1);
	wire win_close  = lock_load | store_hit | win_end;

	// byte returned by an armed load, selected by the pointer
	wire [7:0] nv_byte = (pointer == PTR_FUSE_LOW)  ? fuse_lo :
	                     (pointer == PTR_LOCK)      ? nv.lock_byte :
	                     (pointer == PTR_FUSE_HIGH) ? fuse_hi :
	                     UNMAPPED_BYTE;

	// arming window counts cpu cycles from the one after the control write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd      <= '0;
			win_open <= 1'b0;
			win_cnt  <= '0;
		end else if (ctrl_wr) begin
			cmd      <= wr_data[CTL_SPM_EN] ? wr_data[CTL_CMD_W-1:0] : '0;
			win_open <= wr_data[CTL_SPM_EN];
			win_cnt  <= '0;
		end else if (win_close) begin
			cmd      <= '0;
			win_open <= 1'b0;
		end else if (win_open) begin
			win_cnt <= win_cnt + 3'h1;
		end
	end

	// section busy is set by page operations and a re-enable or system reset clears it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rww_busy <= 1'b0;
		else if (start_page)
			rww_busy <= 1'b1;
		else if (reenable)
			rww_busy <= 1'b0;
	end

	// kick the timer; refused stores are reported in status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nv.start      <= 1'b0;
			nv.start_lock <= 1'b0;
			nv.lock_src   <= LOCK_ERASED;
			store_refused <= 1'b0;
			flash_busy    <= 1'b0;
		end else begin
			nv.start      <= start_lock | start_page;
			nv.start_lock <= start_lock;
			nv.lock_src   <= source;
			flash_busy    <= nv.busy | nv.start;
			if (store_hit)
				store_refused <= ~store_ok;
		end
	end

	// load results; flash stays readable during every lock write
	logic [7:0] res_data;
	logic       res_valid, res_refused, pmem_pend;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_data    <= '0;
			res_valid   <= 1'b0;
			res_refused <= 1'b0;
			pmem_pend   <= 1'b0;
		end else if (lock_load) begin
			res_data    <= ee_busy ? res_data : nv_byte;
			res_valid   <= ~ee_busy;
			res_refused <= ee_busy;
		end else if (plain_load) begin
			res_valid   <= 1'b0;
			res_refused <= 1'b0;
			pmem_pend   <= 1'b1;
		end else if (pmem_pend) begin
			res_data  <= pmem_rdata;
			res_valid <= 1'b1;
			pmem_pend <= 1'b0;
		end
	end

	// ordinary program memory read port
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pmem_addr <= '0;
			pmem_rd   <= 1'b0;
		end else begin
			pmem_rd <= plain_load;
			if (plain_load)
				pmem_addr <= pointer;
		end
	end

	// program-enable stays visible until the timed write is over
	wire spm_en_view = cmd[CTL_SPM_EN] | nv.busy | nv.start;

	// read decode and data mux
	wire [5:0]  rd_idx  = s_axi_araddr[7:2];
	wire        rd_map  = rd_idx <= OFS_STATUS[7:2];
	wire [31:0] rd_word =
		(rd_idx == OFS_CTRL[7:2])    ? {25'h000_0000, rww_busy, 1'b0,
		                                cmd[CTL_CMD_W-1:1], spm_en_view} :
		(rd_idx == OFS_POINTER[7:2]) ? {16'h0000, pointer} :
		(rd_idx == OFS_SOURCE[7:2])  ? {24'h00_0000, source} :
		(rd_idx == OFS_RESULT[7:2])  ? {22'h00_0000, res_refused, res_valid, res_data} :
		(rd_idx == OFS_STATUS[7:2])  ? {28'h000_0000, store_refused, win_open,
		                                nv.busy, ee_busy} :
		32'h0000_0000;

	// read channel answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// checks kept beside the logic they guard
	AST_LOCK_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_load && !ee_busy && pointer == 16'h0001
		|=> res_valid && res_data == $past(nv.lock_byte))
		else $error("armed load at lock address did not return lock byte");

	AST_FUSE_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_load && !ee_busy && pointer == 16'h0000
		|=> res_valid && res_data == $past(fuse_lo))
		else $error("armed load at zero did not return fuse low byte");

	AST_FUSE_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_load && !ee_busy && pointer == 16'h0003
		|=> res_valid && res_data == $past(fuse_hi))
		else $error("armed load at three did not return fuse high byte");

	AST_WINDOW_EXPIRE: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_wr && wr_data[0] ##1 (!wr_fire) [*4] |=> !win_open && cmd == 5'h00)
		else $error("arming bits survived beyond the store window");

	AST_LOAD_LATE: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_load |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
		else $error("load accepted after the three-cycle window");

	AST_EE_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
		store_req && ee_busy |=> !nv.start ##1 !nv.start)
		else $error("flash programming started during eeprom write");

	AST_EE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_load && ee_busy |=> res_refused && !res_valid)
		else $error("fuse or lock read allowed during eeprom write");

	AST_PLAIN_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
		load_req && !win_open |=> pmem_rd && pmem_addr == $past(pointer) ##1 res_valid)
		else $error("ordinary load did not read program memory");

	AST_SPMEN_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
		nv.busy && s_axi_arvalid && s_axi_arready && rd_idx == OFS_CTRL[7:2]
		|=> s_axi_rdata[CTL_SPM_EN])
		else $error("program enable dropped while a write is timed");

	AST_RWW_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		start_page |=> rww_busy throughout nv.start [*1])
		else $error("section busy not raised by page operation");

endmodule : self_program_lock_fuse_access
`default_nettype wire

// ===== test/pmem_model.sv
// Purpose: program memory seen by ordinary loads
// Assumes: data is due while the read pulse stands
// Notes:   outside that cycle the byte flips, so stale data never matches
`timescale 1ns/100ps
`default_nettype none
module pmem_model (
	input  wire logic [15:0] pmem_addr,  // byte address
	input  wire logic        pmem_rd,    // read pulse
	output var  logic [7:0]  pmem_rdata  // read data
);
	// contents are the address folded with a pattern; the load samples it under the pulse
	always_comb begin
		pmem_rdata = pmem_rd ? (pmem_addr[7:0] ^ 8'h3c) : ~(pmem_addr[7:0] ^ 8'h3c);
	end
endmodule : pmem_model
`default_nettype wire

// ===== test/tb_self_program_lock_fuse_access.sv
// Purpose: self-checking bench for lock and fuse access
// Assumes: bus answers are awaited, never counted
// Notes:   short write timer so timed writes last a few rc periods
`timescale 1ns/100ps
`default_nettype none
module tb_self_program_lock_fuse_access;
	import nv_access_pkg::*;
	logic aclk = 0, aresetn = 0, por_n = 0, rc_osc = 0, eeprom_write_busy = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pmem_rdata;
	logic [7:0] fuse_low_byte = 8'h5e, fuse_high_byte = 8'hc9;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, pmem_rd, flash_busy;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [15:0] pmem_addr;
	logic [23:0] rows [4] = '{24'h0000_5e, 24'h0001_ff, 24'h0003_c9, 24'h0002_ff};
	int n_mismatch = 0, checks_done = 0, cnt;
	self_program_lock_fuse_access #(.PROG_TICKS(4)) dut (.*);
	pmem_model pm (.pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata));
	// rc period is ten cpu cycles and unrelated in phase
	initial forever #2 aclk = ~aclk;
	initial begin
		#3.3;
		forever #20 rc_osc = ~rc_osc;
	end
	task automatic close_out;
		if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// each channel released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	// armed load: window opened by the control write, load right after
	task automatic armed_load(input logic [15:0] p);
		wr(OFS_POINTER, {16'h0, p});
		wr(OFS_CTRL, 32'h9);
		wr(OFS_INSTR, 32'h2);
		rd(OFS_RESULT);
	endtask : armed_load
	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		por_n <= 1;
		@(posedge aclk);
		rd(OFS_CTRL);
		chk("ctrl_reset", 32'h0, d);
		rd(8'h20);
		chk("unmapped_resp", RESP_SLVERR, r);
		wr(8'h20, 32'h0);
		chk("unmapped_bresp", RESP_SLVERR, r);
		for (int i = 0; i < 4; i++) begin
			armed_load(rows[i][23:8]);
			chk("armed_load", {22'h0, 2'b01, rows[i][7:0]}, d);
			rd(OFS_CTRL);
			chk("arm_cleared", 4'h0, d[3:0]);
		end
		// window left to run out, then a plain load
		wr(OFS_POINTER, 32'h3);
		chk("bresp_okay", RESP_OKAY, r);
		wr(OFS_CTRL, 32'h9);
		repeat (5) @(posedge aclk);
		rd(OFS_STATUS);
		chk("window_shut", 1'b0, d[ST_WINDOW]);
		wr(OFS_INSTR, 32'h2);
		rd(OFS_RESULT);
		chk("plain_load", {22'h0, 2'b01, 8'h3f}, d);
		// eeprom busy refuses reads and stores
		eeprom_write_busy <= 1;
		repeat (4) @(posedge aclk);
		armed_load(16'h0);
		chk("ee_load", 2'b10, d[9:8]);
		wr(OFS_CTRL, 32'h9);
		wr(OFS_INSTR, 32'h1);
		rd(OFS_STATUS);
		chk("ee_store", 4'b1001, d[3:0]);
		eeprom_write_busy <= 0;
		do rd(OFS_STATUS); while (d[ST_EE_BUSY] !== 1'b0);
		// lock write survives a reset in flight
		wr(OFS_POINTER, 32'h1);
		wr(OFS_SOURCE, 32'heb);
		wr(OFS_CTRL, 32'h9);
		wr(OFS_INSTR, 32'h1);
		rd(OFS_CTRL);
		chk("enable_busy", 1'b1, d[CTL_SPM_EN]);
		wr(OFS_INSTR, 32'h2);
		rd(OFS_RESULT);
		chk("read_in_write", {22'h0, 2'b01, 8'h3d}, d);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(OFS_STATUS);
		chk("busy_past_reset", 1'b1, d[ST_WR_BUSY]);
		repeat (200) @(posedge aclk);
		armed_load(16'h1);
		chk("lock_prog", {22'h0, 2'b01, 8'heb}, d);
		// page write: duration in rc ticks, section busy until re-enabled
		wr(OFS_CTRL, 32'h5);
		wr(OFS_INSTR, 32'h1);
		rd(OFS_CTRL);
		chk("sect_busy", 1'b1, d[CTL_RWW_BUSY]);
		cnt = 0;
		while (flash_busy === 1'b1 && cnt < 500) begin
			@(posedge aclk);
			cnt++;
		end
		chk("write_len", 1'b1, cnt >= 20 && cnt <= 60);
		wr(OFS_CTRL, 32'h11);
		wr(OFS_INSTR, 32'h1);
		rd(OFS_CTRL);
		chk("sect_free", 1'b0, d[CTL_RWW_BUSY]);
		// page erase raises section busy as well
		wr(OFS_CTRL, 32'h3);
		wr(OFS_INSTR, 32'h1);
		rd(OFS_CTRL);
		chk("erase_busy", 1'b1, d[CTL_RWW_BUSY]);
		close_out();
	end
endmodule : tb_self_program_lock_fuse_access
`default_nettype wire
